// >>> logic/dcf_consts.svh
// constants for the 18-bit dual-port fifo with programmable flags
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH
`define DCF_WIDTH        18
`define DCF_DEPTH        64
`define DCF_AW           6
`define DCF_HALF         7'h00_20
`define DCF_AE_LSB       0
`define DCF_AF_LSB       9
`define DCF_OFS_W        9
`define DCF_OFS_RESET    18'h0_1008
`define DCF_SYNC_STAGES  2
`endif

// >>> logic/dcf_pkg.sv
// types shared by the fifo design
`include "dcf_consts.svh"
package dcf_pkg;
  typedef logic [`DCF_WIDTH-1:0] dcf_word_t;
  typedef logic [`DCF_AW:0]      dcf_ptr_t;
  typedef struct packed {
    logic emptyN;
    logic fullN;
    logic almostEmptyN;
    logic almostFullN;
    logic halfFullN;
  } dcf_flags_t;
  typedef enum logic [1:0] {
    DCF_TOK_IDLE = 2'b01,
    DCF_TOK_HELD = 2'b10
  } dcf_tok_t;
endpackage

// >>> logic/dcf_fifo.sv
// 18-bit fifo with programmable almost flags, retransmit and depth-expansion tokens
`timescale 1ns/1ps
`include "dcf_consts.svh"
module dcf_fifo
  import dcf_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  wr_clk,
  input  wire logic                  rd_clk,
  input  wire logic [`DCF_WIDTH-1:0] wr_data,
  input  wire logic                  wr_enable_n,
  input  wire logic                  rd_enable_n,
  input  wire logic                  offset_load_n,
  input  wire logic                  reset_n,
  input  wire logic                  output_drive_n,
  input  wire logic                  flag_sync_select,
  input  wire logic                  first_device_sel_n,
  input  wire logic                  replay_strobe,
  input  wire logic                  cascade_mode,
  input  wire logic                  chain_wr_in,
  input  wire logic                  chain_rd_in,
  output logic      [`DCF_WIDTH-1:0] rd_data,
  output logic                       rd_data_oe,
  output logic                       empty_flag,
  output logic                       full_flag,
  output logic                       almost_empty_n,
  output logic                       almost_full_n,
  output logic                       half_full_or_chain_wr_out,
  output logic                       chain_rd_out
);
  localparam int NIN = 13 + `DCF_WIDTH;

  // every pin but sys_clk and rst passes two flops; data and strobes share latency so they stay aligned
  logic [NIN-1:0] pinRaw;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  assign pinRaw = {wr_clk, rd_clk, wr_enable_n, rd_enable_n, offset_load_n, reset_n,
                   output_drive_n, flag_sync_select, first_device_sel_n, replay_strobe,
                   chain_wr_in, chain_rd_in, cascade_mode, wr_data};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        sync1_q[gi] <= pinRaw[gi];
        sync2_q[gi] <= sync1_q[gi];
      end
    end
  endgenerate

  logic      wrClkS, rdClkS, wrEnN, rdEnN, loadN, resetNS, oeN, syncSel;
  logic      firstN, replayS, chainWrIn, chainRdIn, cascadeS;
  dcf_word_t wrDataS;
  assign {wrClkS, rdClkS, wrEnN, rdEnN, loadN, resetNS, oeN, syncSel,
          firstN, replayS, chainWrIn, chainRdIn, cascadeS, wrDataS} = sync2_q;

  // edge detection looks only at the second stage and a third history flop
  logic wrClkPrev_q, rdClkPrev_q, replayPrev_q, chainWrPrev_q, chainRdPrev_q;
  always_ff @(posedge sys_clk) begin
    wrClkPrev_q   <= wrClkS;
    rdClkPrev_q   <= rdClkS;
    replayPrev_q  <= replayS;
    chainWrPrev_q <= chainWrIn;
    chainRdPrev_q <= chainRdIn;
  end

  logic wrEdge, rdEdge, clear, replayEdge, chainWrFall, chainRdFall;
  assign wrEdge      = wrClkS & ~wrClkPrev_q;
  assign rdEdge      = rdClkS & ~rdClkPrev_q;
  assign clear       = rst | ~resetNS;
  assign replayEdge  = replayS & ~replayPrev_q & ~cascadeS;
  assign chainWrFall = ~chainWrIn & chainWrPrev_q;
  assign chainRdFall = ~chainRdIn & chainRdPrev_q;

  // storage and pointers all live in the sys_clk domain, so no pointer
  // ever crosses clocks; full_flag and the clocked almost_full_n wait for a write edge, so a retransmit can leave them overstating space
  dcf_word_t mem_q [`DCF_DEPTH];
  dcf_ptr_t  wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  dcf_ptr_t  count, countNext;
  dcf_word_t offset_q;
  dcf_tok_t  wrTok_q, wrTok_d, rdTok_q, rdTok_d;

  assign count     = wrPtr_q - rdPtr_q;
  assign countNext = wrPtr_d - rdPtr_d;

  logic isEmpty, isFull, wrTokOk, rdTokOk, doWrite, doRead, doLoadWr, doLoadRd;
  assign isEmpty  = (count == '0);
  assign isFull   = (count == dcf_ptr_t'(`DCF_DEPTH));
  assign wrTokOk  = ~cascadeS | (wrTok_q == DCF_TOK_HELD);
  assign rdTokOk  = ~cascadeS | (rdTok_q == DCF_TOK_HELD);
  assign doLoadWr = wrEdge & ~wrEnN & ~loadN;
  assign doLoadRd = rdEdge & ~rdEnN & ~loadN;
  assign doWrite  = wrEdge & ~wrEnN & loadN & ~isFull & wrTokOk;
  assign doRead   = rdEdge & ~rdEnN & loadN & ~isEmpty & rdTokOk;

  assign wrPtr_d = doWrite ? wrPtr_q + 1'b1 : wrPtr_q;
  // rewind goes to location zero; the write pointer is untouched
  assign rdPtr_d = replayEdge ? '0 : (doRead ? rdPtr_q + 1'b1 : rdPtr_q);

  // tokens pass on the write or read of the last location of this device
  logic wrLast, rdLast;
  assign wrLast  = doWrite & (wrPtr_q[`DCF_AW-1:0] == '1);
  assign rdLast  = doRead & (rdPtr_q[`DCF_AW-1:0] == '1);
  assign wrTok_d = wrLast ? DCF_TOK_IDLE : (chainWrFall ? DCF_TOK_HELD : wrTok_q);
  assign rdTok_d = rdLast ? DCF_TOK_IDLE : (chainRdFall ? DCF_TOK_HELD : rdTok_q);

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  // on reset_n the first device in the chain starts with both tokens; rst leaves both idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrTok_q <= DCF_TOK_IDLE;
      rdTok_q <= DCF_TOK_IDLE;
    end else if (~resetNS) begin
      wrTok_q <= firstN ? DCF_TOK_IDLE : DCF_TOK_HELD;
      rdTok_q <= firstN ? DCF_TOK_IDLE : DCF_TOK_HELD;
    end else begin
      wrTok_q <= wrTok_d;
      rdTok_q <= rdTok_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem_q[wrPtr_q[`DCF_AW-1:0]] <= wrDataS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      offset_q <= `DCF_OFS_RESET;
    end else if (doLoadWr) begin
      offset_q <= wrDataS;
    end
  end

  // read data register; the offset is read back whole
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      rd_data <= '0;
    end else if (doLoadRd) begin
      rd_data <= offset_q;
    end else if (doRead) begin
      rd_data <= mem_q[rdPtr_q[`DCF_AW-1:0]];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_oe <= 1'b0;
    end else begin
      rd_data_oe <= ~oeN;
    end
  end

  // almost thresholds from the offset register fields
  logic [`DCF_OFS_W-1:0] aeOfs, afOfs;
  assign aeOfs = offset_q[`DCF_AE_LSB +: `DCF_OFS_W];
  assign afOfs = offset_q[`DCF_AF_LSB +: `DCF_OFS_W];

  logic aeNow, afNow, aeNext, afNext;
  assign aeNow  = ({2'b00, count} <= aeOfs);
  assign afNow  = ({2'b00, count} + afOfs >= `DCF_OFS_W'(`DCF_DEPTH));
  assign aeNext = ({2'b00, countNext} <= aeOfs);
  assign afNext = ({2'b00, countNext} + afOfs >= `DCF_OFS_W'(`DCF_DEPTH));

  dcf_flags_t flags_q;
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      flags_q <= '{emptyN: 1'b0, fullN: 1'b1, almostEmptyN: 1'b0,
                   almostFullN: 1'b1, halfFullN: 1'b1};
    end else begin
      if (rdEdge | replayEdge) begin
        flags_q.emptyN       <= (countNext != '0);
        flags_q.almostEmptyN <= ~aeNext;
      end
      if (wrEdge) begin
        flags_q.fullN       <= (countNext != dcf_ptr_t'(`DCF_DEPTH));
        flags_q.almostFullN <= ~afNext;
      end
      flags_q.halfFullN <= ~(countNext > `DCF_HALF);
    end
  end

  assign empty_flag     = flags_q.emptyN;
  assign full_flag      = flags_q.fullN;
  // unclocked mode follows the live count with no wait for either clock
  assign almost_empty_n = syncSel ? ~aeNow : flags_q.almostEmptyN;
  assign almost_full_n  = syncSel ? ~afNow : flags_q.almostFullN;

  // token pulses are one sys_clk low after the last location moves
  logic wrPulseN_q, rdPulseN_q;
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      wrPulseN_q <= 1'b1;
      rdPulseN_q <= 1'b1;
    end else begin
      wrPulseN_q <= ~(wrLast & cascadeS);
      rdPulseN_q <= ~(rdLast & cascadeS);
    end
  end

  assign half_full_or_chain_wr_out = cascadeS ? wrPulseN_q
                                                  : flags_q.halfFullN;
  assign chain_rd_out = rdPulseN_q;
endmodule

// >>> tb/dcf_chk.sv
// port-level assertions for the fifo top
`timescale 1ns/1ps
module dcf_chk
  import dcf_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      rst,
  input wire logic      wr_clk,
  input wire logic      rd_clk,
  input wire logic      output_drive_n,
  input wire logic      flag_sync_select,
  input wire logic      replay_strobe,
  input wire dcf_word_t rd_data,
  input wire logic      rd_data_oe,
  input wire logic      empty_flag,
  input wire logic      full_flag,
  input wire logic      almost_empty_n,
  input wire logic      almost_full_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // port edges pass two sync flops and an edge flop, so flags move three core cycles later
  sequence s_rdSeen; $past(rd_clk, 3) || $past(replay_strobe, 3); endsequence
  sequence s_oeLow; (!output_drive_n)[*5]; endsequence
  sequence s_oeHigh; output_drive_n[*5]; endsequence
  property p_rstClr; $fell(rst) |-> !empty_flag && full_flag && almost_full_n && !rd_data_oe;
  endproperty
  property p_oeOn; s_oeLow |-> rd_data_oe; endproperty
  property p_oeOff; s_oeHigh |-> !rd_data_oe; endproperty
  property p_fullClk; $changed(full_flag) |-> $past(wr_clk, 3); endproperty
  property p_emptyClk; $changed(empty_flag) |-> s_rdSeen; endproperty
  property p_aeClk; !flag_sync_select && $changed(almost_empty_n) |-> s_rdSeen; endproperty
  property p_afClk; !flag_sync_select && $changed(almost_full_n) |-> $past(wr_clk, 3);
  endproperty
  property p_rdHold; $changed(rd_data) |-> $past(rd_clk, 3); endproperty
  a_rstClr: assert property (p_rstClr) else $error("flags not cleared by reset");
  a_oeOn: assert property (p_oeOn) else $error("read bus not driven");
  a_oeOff: assert property (p_oeOff) else $error("read bus driven while disabled");
  a_fullClk: assert property (p_fullClk) else $error("full moved without write edge");
  a_emptyClk: assert property (p_emptyClk) else $error("empty moved without read edge");
  a_aeClk: assert property (p_aeClk) else $error("almost empty off its clock");
  a_afClk: assert property (p_afClk) else $error("almost full off its clock");
  a_rdHold: assert property (p_rdHold) else $error("read data moved without read");
endmodule
bind dcf_fifo dcf_chk i_dcf_chk (.sys_clk(sys_clk), .rst(rst), .wr_clk(wr_clk),
  .rd_clk(rd_clk), .output_drive_n(output_drive_n), .flag_sync_select(flag_sync_select),
  .replay_strobe(replay_strobe), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
  .empty_flag(empty_flag), .full_flag(full_flag), .almost_empty_n(almost_empty_n),
  .almost_full_n(almost_full_n));

// >>> tb/dcf_far_end.sv
// far-side writer and reader: slow port clocks and standalone straps
`timescale 1ns/1ps
module dcf_far_end (
  input  wire logic sys_clk,
  output logic      wr_clk,
  output logic      rd_clk,
  output logic      strapLow
);
  initial begin
    wr_clk = 1'b0;
    rd_clk = 1'b0;
    strapLow = 1'b0;
  end
  // three core cycles per phase keeps sampled edges legally spaced
  task automatic tick(input bit rd);
    if (rd) rd_clk = 1'b1;
    else wr_clk = 1'b1;
    repeat (3) @(negedge sys_clk);
    rd_clk = 1'b0;
    wr_clk = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
endmodule

// >>> tb/dcf_fifo_test.sv
// self-checking bench for the fifo against a behavioural model
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module dcf_fifo_test
  import dcf_pkg::*;
;
  logic sys_clk = 0, rst = 1, wr_enable_n = 1, rd_enable_n = 1, offset_load_n = 1;
  logic reset_n = 0, output_drive_n = 0, flag_sync_select = 0, replay_strobe = 0;
  logic cascade_mode = 0, rd_data_oe, empty_flag, full_flag, almost_empty_n, almost_full_n;
  logic half_full_or_chain_wr_out, chain_rd_out, wr_clk, rd_clk, strapLow;
  wire  chain_wr_in = strapLow, chain_rd_in = strapLow, first_device_sel_n = strapLow;
  dcf_word_t  wr_data = '0, rd_data, rdE, ofs, mem [64];
  dcf_flags_t flE;
  int fail_count, check_count, wrN, rdN, ae, af;
  bit [31:0] seed = 32'h0001_3E65;
  dcf_fifo i_dcf_fifo (.*);
  dcf_far_end i_dcf_far_end (.sys_clk(sys_clk), .wr_clk(wr_clk), .rd_clk(rd_clk),
    .strapLow(strapLow));
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int cnt();
    return wrN - rdN;
  endfunction
  task automatic cmp();
    if (flag_sync_select) begin
      flE.almostEmptyN = cnt() > ae;
      flE.almostFullN = cnt() < 64 - af;
    end
    flE.halfFullN = cnt() <= 32;
    `CHK("flags", flE, {empty_flag, full_flag, almost_empty_n, almost_full_n,
      half_full_or_chain_wr_out})
    `CHK("rd_data", rdE, rd_data)
    `CHK("rd_data_oe", !output_drive_n, rd_data_oe)
    `CHK("chain_rd_out", 1'b1, chain_rd_out)
  endtask
  task automatic op(input bit rd, input bit ld, input dcf_word_t d);
    offset_load_n = !ld;
    wr_data = d;
    if (rd) rd_enable_n = 0;
    else wr_enable_n = 0;
    i_dcf_far_end.tick(rd);
    rd_enable_n = 1;
    wr_enable_n = 1;
    offset_load_n = 1;
    if (ld && rd) rdE = ofs;
    else if (ld) ofs = d;
    else if (!rd && cnt() < 64) begin mem[wrN % 64] = d; wrN++; end
    else if (rd && cnt() > 0) begin rdE = mem[rdN % 64]; rdN++; end
    ae = ofs[8:0];
    af = ofs[17:9];
    // clocked flags only move on their own port edge or, for the empty side, a retransmit
    if (!ld && rd) begin flE.emptyN = cnt() != 0; flE.almostEmptyN = cnt() > ae; end
    if (!ld && !rd) begin flE.fullN = cnt() != 64; flE.almostFullN = cnt() < 64 - af; end
    cmp();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  initial begin repeat (5000) @(posedge sys_clk); fail_count++; wrap_up(); end
  initial begin
    bit [31:0] v;
    repeat (16) @(negedge sys_clk);
    rst = 0;
    reset_n = 1;
    repeat (6) @(negedge sys_clk);
    flE = 5'h0B;
    rdE = '0;
    ofs = 18'h0_1008;
    cmp();
    v = rnd();
    op(0, 1, {5'h00, v[3:0], 5'h00, v[7:4]});
    op(1, 1, '0);
    repeat (40) op(0, 0, 18'(rnd()));
    repeat (10) op(1, 0, '0);
    replay_strobe = 1;
    repeat (3) @(negedge sys_clk);
    replay_strobe = 0;
    repeat (6) @(negedge sys_clk);
    rdN = 0;
    flE.emptyN = cnt() != 0;
    flE.almostEmptyN = cnt() > ae;
    cmp();
    repeat (41) op(1, 0, '0);
    repeat (65) op(0, 0, 18'(rnd()));
    output_drive_n = 1;
    repeat (6) @(negedge sys_clk);
    cmp();
    output_drive_n = 0;
    flag_sync_select = 1;
    repeat (6) @(negedge sys_clk);
    cmp();
    repeat (30) op(1, 0, '0);
    repeat (3) op(0, 0, 18'(rnd()));
    wrap_up();
  end
endmodule
